// file: hdl/dbs_pin_sram.sv
// Pin-level DDR burst-of-four common-I/O SRAM, device side.
//
// Behaviour
// (RULE1) Address and control are captured only on rising positive input clock.
// (RULE2) Write data is captured on rising edges of both input clocks.
// (RULE3) Controller drives negative input clock as complement of positive one.
// (RULE4) Read data is launched on the output clock pair edges.
// (RULE5) Echo clocks run continuously, also while data outputs float.
// (RULE6) Echo clock edges line up with read data transitions.
// (RULE7) DLL-off low bypasses the DLL and clears any lock state.
// (RULE8) DLL-off high starts locking; controller waits lock time.
// (RULE9) DLL disabled gives single-cycle read latency; clock is limited.
// (RULE10) Address registered on positive clock edge; ignored when deselected.
// (RULE11) Controller presents write data around both input clock edges.
// (RULE12) Read data follows output clocks, or input clocks when both tied high.
// (RULE13) Data bus is driven only during a read, otherwise released.
// (RULE14) Narrow configuration uses only the lower eighteen data lines.
// (RULE15) Wide configuration uses all thirty-six data lines both ways.
// (RULE16) With load low, read/write high selects read, low selects write.
// (RULE17) Controller drives load low for each new operation.
// (RULE18) A byte is stored only when its byte-write strobe is low.
// (RULE19) All reads and writes are fixed bursts of four words.
// (RULE20) Controller releases the data bus while the device drives reads.
`timescale 1ns/1ps
`include "dbs_regs.svh"
module dbs_pin_sram (
  input  wire logic             i_ref_clk,       // 200 MHz reference clock.
  input  wire logic             i_reset_n,       // Async reset, low.
  input  wire logic             i_in_clk_pos,    // Positive input clock.
  input  wire logic             i_in_clk_neg,    // Negative input clock.
  input  wire logic             i_out_clk_pos,   // Positive output clock.
  input  wire logic             i_out_clk_neg,   // Negative output clock.
  input  wire logic             i_dll_off_n,     // DLL off when low.
  input  wire logic             i_load_strobe_n, // Load strobe, low.
  input  wire logic             i_read_write,    // High read, low write.
  input  wire logic             i_wide_cfg,      // Strap, high for 36 bits.
  input  wire logic [3:0]       i_byte_write_n,  // Byte strobes, low.
  input  wire dbs_pkg::dbs_adr_t i_sync_address, // Burst address.
  input  wire dbs_pkg::dbs_dq_t i_bidir_data_bus, // Data bus input side.
  output dbs_pkg::dbs_dq_t      o_bidir_data_bus, // Data bus output side.
  output logic [1:0]            o_bidir_data_oe, // Enables, low/high half.
  output logic                  o_echo_clock_pos, // Positive echo clock.
  output logic                  o_echo_clock_neg, // Negative echo clock.
  output logic                  o_dll_locked     // DLL lock indication.
);
  import dbs_pkg::*;

  logic [`DBS_SYNC_W-1:0] pins;
  logic [`DBS_SYNC_W-1:0] lvl;
  logic [`DBS_SYNC_W-1:0] rise;
  logic                   k_rise;
  logic                   kn_rise;
  logic                   ld_n;
  logic [3:0]             bw_n;
  dbs_adr_t               adr;
  dbs_dq_t                dq_in;
  logic [5:0]             tie_cnt_reg;
  logic                   tied_reg;
  logic                   src_pos;
  logic                   src_neg;
  logic                   out_edge;
  logic [10:0]            lock_cnt_reg;
  logic [1:0]             strap_cnt_reg;
  logic                   wide_reg;
  logic                   rd_cmd;
  logic                   wr_cmd;
  logic                   pend_rd_reg;
  dbs_adr_t               pend_rd_adr_reg;
  logic [1:0]             pend_cnt_reg;
  dbs_adr_t               act_adr_reg;
  logic [1:0]             rd_idx_reg;
  dbs_rd_e                rd_state_reg;
  logic                   launch;
  logic                   emit;
  dbs_widx_t              rd_index;
  dbs_dq_t                rd_word;
  logic                   wr_pend_reg;
  dbs_adr_t               wr_pend_adr_reg;
  dbs_adr_t               wr_cur_adr_reg;
  logic [1:0]             wr_idx_reg;
  logic                   wr_busy_reg;
  logic                   wr_start;
  logic                   wr_cap;
  logic                   wr_en;
  dbs_widx_t              wr_index;
  logic [3:0]             lane_en;
  logic [3:0]             lane_on;

  // Byte lanes that carry data in the present width.
  function automatic logic [3:0] lane_mask(input logic wide);
    lane_mask = wide ? 4'hF : 4'h3;
  endfunction

  // ========================================================================
  // Pin synchronisation; every pin passes two flip-flops.
  assign pins = {i_bidir_data_bus, i_sync_address, i_byte_write_n,
                 i_wide_cfg, i_read_write, i_load_strobe_n, i_dll_off_n,
                 i_out_clk_neg, i_out_clk_pos, i_in_clk_neg, i_in_clk_pos};

  dbs_pin_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (pins),
    .o_level   (lvl),
    .o_rise    (rise)
  );

  // Decoded pin fields.
  assign k_rise  = rise[`DBS_P_K];
  assign kn_rise = rise[`DBS_P_KN];
  assign ld_n    = lvl[`DBS_P_LD];
  assign bw_n    = lvl[`DBS_P_BW_LO +: 4];
  assign adr     = lvl[`DBS_P_ADR_LO +: `DBS_ADR_W];
  assign dq_in   = lvl[`DBS_P_DQ_LO +: `DBS_DQ_W];

  // ========================================================================
  // Output clocks count as tied when both stay high for a while.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tie_cnt_reg <= 6'h00;
      tied_reg    <= 1'b0;
    end else if (lvl[`DBS_P_C] && lvl[`DBS_P_CN]) begin
      if (tie_cnt_reg != `DBS_TIE_CYC) begin
        tie_cnt_reg <= tie_cnt_reg + 6'h01;
      end
      tied_reg <= (tie_cnt_reg == `DBS_TIE_CYC);
    end else begin
      tie_cnt_reg <= 6'h00;
      tied_reg    <= 1'b0;
    end
  end

  // Output timing source: output clocks, or input clocks when tied.
  assign src_pos  = tied_reg ? lvl[`DBS_P_K] : lvl[`DBS_P_C]; // [RULE12]
  assign src_neg  = tied_reg ? lvl[`DBS_P_KN] : lvl[`DBS_P_CN]; // [RULE12]
  assign out_edge = tied_reg ? (k_rise | kn_rise) :
                    (rise[`DBS_P_C] | rise[`DBS_P_CN]); // [RULE4]

  // Echo clocks follow the timing source without stopping.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_echo_clock_pos <= 1'b0;
      o_echo_clock_neg <= 1'b0;
    end else begin
      o_echo_clock_pos <= src_pos; // [RULE5] [RULE6]
      o_echo_clock_neg <= src_neg; // [RULE5] [RULE6]
    end
  end

  // ========================================================================
  // DLL model: cleared while off, locks after a count of input clocks.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_cnt_reg <= 11'h000;
      o_dll_locked <= 1'b0;
    end else if (!lvl[`DBS_P_DOFF]) begin
      lock_cnt_reg <= 11'h000; // [RULE7]
      o_dll_locked <= 1'b0; // [RULE7]
    end else if (k_rise && !o_dll_locked) begin
      lock_cnt_reg <= lock_cnt_reg + 11'h001; // [RULE8]
      o_dll_locked <= (lock_cnt_reg == `DBS_LOCK_KCYC - 11'h001);
    end
  end

  // Width strap is caught once the synchroniser has settled.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_cnt_reg <= 2'h0;
      wide_reg      <= 1'b0;
    end else if (strap_cnt_reg != `DBS_STRAP_CYC) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      wide_reg      <= lvl[`DBS_P_WIDE];
    end
  end

  // ========================================================================
  // Commands are taken on the positive clock edge with load low only.
  assign rd_cmd = k_rise && !ld_n && lvl[`DBS_P_RW]; // [RULE1] [RULE16]
  assign wr_cmd = k_rise && !ld_n && !lvl[`DBS_P_RW]; // [RULE1] [RULE16]

  // Lanes that the present width reads back.
  assign lane_on = lane_mask(wide_reg); // [RULE14]

  // Storage, one array per nine-bit byte lane.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      logic [8:0] mem [2**(`DBS_MEM_AW+2)];
      always_ff @(posedge i_ref_clk) begin
        if (wr_en && lane_en[g]) begin
          mem[wr_index] <= dq_in[9*g +: 9]; // [RULE18]
        end
      end
      assign rd_word[9*g +: 9] = lane_on[g] ?
                                 mem[rd_index] : 9'h000; // [RULE14]
    end
  endgenerate

  // ========================================================================
  // Write bursts: word 0 at the next positive edge, then alternate edges.
  assign wr_start = k_rise && wr_pend_reg; // [RULE2]
  assign wr_cap   = wr_busy_reg &&
                    (wr_idx_reg[0] ? kn_rise : k_rise); // [RULE2]
  assign wr_en    = wr_start || wr_cap;
  assign wr_index = wr_start ? {wr_pend_adr_reg[`DBS_MEM_AW-1:0], 2'h0} :
                    {wr_cur_adr_reg[`DBS_MEM_AW-1:0], wr_idx_reg};
  assign lane_en  = ~bw_n & lane_mask(wide_reg); // [RULE18] [RULE15]

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_reg     <= 1'b0;
      wr_pend_adr_reg <= '0;
      wr_cur_adr_reg  <= '0;
      wr_idx_reg      <= 2'h0;
      wr_busy_reg     <= 1'b0;
    end else begin
      if (wr_start) begin
        wr_pend_reg    <= 1'b0;
        wr_cur_adr_reg <= wr_pend_adr_reg;
        wr_idx_reg     <= 2'h1;
        wr_busy_reg    <= 1'b1;
      end else if (wr_cap) begin
        wr_idx_reg  <= wr_idx_reg + 2'h1;
        wr_busy_reg <= (wr_idx_reg != 2'h3); // [RULE19]
      end
      if (wr_cmd) begin
        wr_pend_reg     <= 1'b1;
        wr_pend_adr_reg <= adr; // [RULE10]
      end
    end
  end

  // ========================================================================
  // Read bursts: wait a latency in output edges, then four words.
  assign launch   = out_edge && pend_rd_reg && (pend_cnt_reg == 2'h1);
  assign emit     = launch || (out_edge && rd_state_reg == DBS_RD_BURST);
  assign rd_index = launch ? {pend_rd_adr_reg[`DBS_MEM_AW-1:0], 2'h0} :
                    {act_adr_reg[`DBS_MEM_AW-1:0], rd_idx_reg};

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_rd_reg     <= 1'b0;
      pend_rd_adr_reg <= '0;
      pend_cnt_reg    <= 2'h0;
    end else if (rd_cmd) begin
      pend_rd_reg     <= 1'b1;
      pend_rd_adr_reg <= adr; // [RULE10]
      pend_cnt_reg    <= o_dll_locked ? `DBS_LAT_DLL : `DBS_LAT_OFF; // [RULE9]
    end else if (launch) begin
      pend_rd_reg <= 1'b0;
    end else if (out_edge && pend_rd_reg) begin
      pend_cnt_reg <= pend_cnt_reg - 2'h1;
    end
  end

  // Burst sequencer and word index.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_state_reg <= DBS_RD_IDLE;
      act_adr_reg  <= '0;
      rd_idx_reg   <= 2'h0;
    end else if (launch) begin
      rd_state_reg <= DBS_RD_BURST;
      act_adr_reg  <= pend_rd_adr_reg;
      rd_idx_reg   <= 2'h1;
    end else if (emit) begin
      rd_idx_reg <= rd_idx_reg + 2'h1;
      if (rd_idx_reg == 2'h3) begin
        rd_state_reg <= DBS_RD_IDLE; // [RULE19]
      end
    end
  end

  // Data and enables change only on output edges.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bidir_data_bus <= '0;
      o_bidir_data_oe  <= 2'h0;
    end else if (emit) begin
      o_bidir_data_bus <= rd_word; // [RULE4]
      o_bidir_data_oe  <= {wide_reg, 1'b1}; // [RULE13] [RULE15]
    end else if (out_edge) begin
      o_bidir_data_oe <= 2'h0; // [RULE13]
    end
  end

  // ========================================================================
  // Checks.
  oe_needs_read_a: assert property (@(posedge i_ref_clk) // [RULE13]
    disable iff (!i_reset_n)
    $rose(o_bidir_data_oe[0]) |-> $past(launch))
    else $error("Data bus enabled without a read launch.");
  narrow_upper_a: assert property (@(posedge i_ref_clk) // [RULE14]
    disable iff (!i_reset_n)
    !wide_reg |-> !o_bidir_data_oe[1] &&
                  o_bidir_data_bus[35:18] == '0)
    else $error("Upper data lines used in narrow mode.");
  wide_both_a: assert property (@(posedge i_ref_clk) // [RULE15]
    disable iff (!i_reset_n)
    (o_bidir_data_oe[0] && wide_reg) |-> o_bidir_data_oe[1])
    else $error("Upper half not driven in wide mode.");
  dll_off_clear_a: assert property (@(posedge i_ref_clk) // [RULE7]
    disable iff (!i_reset_n)
    !lvl[`DBS_P_DOFF] |=> !o_dll_locked && lock_cnt_reg == 11'h000)
    else $error("DLL state kept while disabled.");
  dll_lock_a: assert property (@(posedge i_ref_clk) // [RULE8]
    disable iff (!i_reset_n)
    $rose(o_dll_locked) |->
      $past(lock_cnt_reg) == `DBS_LOCK_KCYC - 11'h001)
    else $error("DLL locked after wrong count.");
  single_lat_a: assert property (@(posedge i_ref_clk) // [RULE9]
    disable iff (!i_reset_n)
    (rd_cmd && !o_dll_locked) |=> pend_cnt_reg == 2'h2)
    else $error("Wrong latency with DLL off.");
  deselect_a: assert property (@(posedge i_ref_clk) // [RULE10]
    disable iff (!i_reset_n)
    (k_rise && ld_n) |=>
      $stable(pend_rd_adr_reg) && $stable(wr_pend_adr_reg))
    else $error("Address taken while deselected.");
  echo_align_a: assert property (@(posedge i_ref_clk) // [RULE6]
    disable iff (!i_reset_n)
    $changed(o_bidir_data_bus) |-> $past(out_edge))
    else $error("Data changed away from an echo edge.");
  burst_four_a: assert property (@(posedge i_ref_clk) // [RULE19]
    disable iff (!i_reset_n)
    (emit && !launch && rd_idx_reg == 2'h3) |=>
      rd_state_reg == DBS_RD_IDLE)
    else $error("Read burst not four words.");
endmodule

// file: hdl/dbs_regs.svh
// Bit positions and timing counts of the burst SRAM pin interface.
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH
// ==========================================================================
// Positions of the pins in the synchroniser vector.
`define DBS_SYNC_W     66
`define DBS_P_K        0
`define DBS_P_KN       1
`define DBS_P_C        2
`define DBS_P_CN       3
`define DBS_P_DOFF     4
`define DBS_P_LD       5
`define DBS_P_RW       6
`define DBS_P_WIDE     7
`define DBS_P_BW_LO    8
`define DBS_P_ADR_LO   12
`define DBS_P_DQ_LO    30
// ==========================================================================
// Widths, storage depth and timing counts.
`define DBS_ADR_W      18
`define DBS_DQ_W       36
`define DBS_MEM_AW     6
`define DBS_TIE_CYC    6'h20
`define DBS_LOCK_KCYC  11'h400
`define DBS_LAT_DLL    2'h3
`define DBS_LAT_OFF    2'h2
`define DBS_STRAP_CYC  2'h3
`endif

// file: hdl/dbs_pkg.sv
// Types shared by the burst SRAM pin interface.
`include "dbs_regs.svh"
package dbs_pkg;
  typedef logic [`DBS_ADR_W-1:0] dbs_adr_t;
  typedef logic [`DBS_DQ_W-1:0]  dbs_dq_t;
  typedef logic [`DBS_MEM_AW+1:0] dbs_widx_t;
  // Read launch states.
  typedef enum logic [1:0] {
    DBS_RD_IDLE  = 2'b01,
    DBS_RD_BURST = 2'b10
  } dbs_rd_e;
endpackage

// file: hdl/dbs_pin_sync.sv
// Two-stage synchroniser with rise detection for all pins.
`timescale 1ns/1ps
`include "dbs_regs.svh"
module dbs_pin_sync (
  input  wire logic                   i_ref_clk, // Reference clock.
  input  wire logic                   i_reset_n, // Async reset, low.
  input  wire logic [`DBS_SYNC_W-1:0] i_pins,    // Raw pin levels.
  output logic      [`DBS_SYNC_W-1:0] o_level,   // Synchronised levels.
  output logic      [`DBS_SYNC_W-1:0] o_rise     // One-cycle rise pulses.
);
  logic [`DBS_SYNC_W-1:0] meta_reg;
  logic [`DBS_SYNC_W-1:0] lvl_reg;
  logic [`DBS_SYNC_W-1:0] prev_reg;
  logic [2:0]             fill_reg;

  // ========================================================================
  // Synchroniser chain; the second stage and its delayed copy feed the edge detector.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      lvl_reg  <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= i_pins;
      lvl_reg  <= meta_reg;
      prev_reg <= lvl_reg;
    end
  end

  // Edges are held off until the chain holds real pin levels, so that a
  // pin idling high does not look like a rise just after reset.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill_reg <= 3'h0;
    end else begin
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  // Levels and rising edges as seen in the reference domain.
  assign o_level = lvl_reg;
  assign o_rise  = (lvl_reg & ~prev_reg) & {`DBS_SYNC_W{fill_reg[2]}};
endmodule

// file: dv/dbs_ctl_model.sv
// Controller-side clock model for the burst SRAM pin interface.
`timescale 1ns/1ps
module dbs_ctl_model (
  input  wire logic i_tie_out,     // High holds output clocks high.
  output logic      o_in_clk_pos,  // Positive input clock.
  output logic      o_in_clk_neg,  // Negative input clock.
  output logic      o_out_clk_pos, // Positive output clock.
  output logic      o_out_clk_neg  // Negative output clock.
);
  // ==========================================================
  // Free-running 64 ns input clock, phase unrelated to ref clock.
  initial begin
    o_in_clk_pos = 1'b0;
    #1.3;
    forever #32 o_in_clk_pos = ~o_in_clk_pos;
  end
  // Negative clock is the exact complement, half a period apart.
  assign o_in_clk_neg  = ~o_in_clk_pos;
  // Output clocks copy the input pair, or sit high when tied.
  assign o_out_clk_pos = i_tie_out | o_in_clk_pos;
  assign o_out_clk_neg = i_tie_out | o_in_clk_neg;
endmodule

// file: dv/dbs_pin_sram_tb_top.sv
// Self-checking bench for the burst SRAM pin interface.
`timescale 1ns/1ps
module dbs_pin_sram_tb_top;
  import dbs_pkg::*;
  // ==========================================================
  // Pins, counters and fixed patterns.
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          dll_off_n = 1'b0;
  logic          ld_n = 1'b1;
  logic          rw = 1'b1;
  logic          wide = 1'b1;
  logic          tie = 1'b0;
  logic [3:0]    bw_n = 4'hF;
  dbs_adr_t      adr = '0;
  dbs_dq_t       drv = '0;
  dbs_dq_t       bus;
  dbs_dq_t       q;
  logic [1:0]    oe;
  logic          kp, kn, cp, cn, ep, en, lk;
  int            num_errors = 0;
  int            tests_run = 0;
  dbs_dq_t [3:0] exp_mem;
  localparam dbs_adr_t A0 = 18'h00005;
  localparam dbs_adr_t A1 = 18'h0002A;
  localparam dbs_dq_t [3:0] D0 = {36'h1_2345_6789, 36'hF_EDCB_A987,
                                  36'h5_A5A5_A5A5, 36'hC_3C3C_3C3C};
  localparam dbs_dq_t [3:0] D1 = {36'h0_F0F0_F0F0, 36'h9_8765_4321,
                                  36'h3_0C30_C30C, 36'hE_1E1E_1E1E};
  wire sp = tie ? kp : cp;
  wire sn = tie ? kn : cn;
  // Reference clock, 5 ns period.
  always #2.5 clk = ~clk;
  // Each bus half carries the device while it drives, else the bench.
  assign bus[17:0]  = oe[0] ? q[17:0] : drv[17:0];
  assign bus[35:18] = oe[1] ? q[35:18] : drv[35:18];
  // ==========================================================
  // Controller model and device.
  dbs_ctl_model ctl (
    .i_tie_out     (tie),
    .o_in_clk_pos  (kp),
    .o_in_clk_neg  (kn),
    .o_out_clk_pos (cp),
    .o_out_clk_neg (cn)
  );
  dbs_pin_sram dut (
    .i_ref_clk        (clk),
    .i_reset_n        (rst_n),
    .i_in_clk_pos     (kp),
    .i_in_clk_neg     (kn),
    .i_out_clk_pos    (cp),
    .i_out_clk_neg    (cn),
    .i_dll_off_n      (dll_off_n),
    .i_load_strobe_n  (ld_n),
    .i_read_write     (rw),
    .i_wide_cfg       (wide),
    .i_byte_write_n   (bw_n),
    .i_sync_address   (adr),
    .i_bidir_data_bus (bus),
    .o_bidir_data_bus (q),
    .o_bidir_data_oe  (oe),
    .o_echo_clock_pos (ep),
    .o_echo_clock_neg (en),
    .o_dll_locked     (lk)
  );
  // ==========================================================
  // Shared helpers.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] pick(input int s);
    case (s)
      0: pick = {1'b0, kp};
      1: pick = {1'b0, kn};
      default: pick = {sp, sn};
    endcase
  endfunction
  function automatic dbs_dq_t lanes(input logic [3:0] b);
    lanes = '0;
    for (int g = 0; g < 4; g++) begin
      if (!b[g]) begin
        lanes[9*g +: 9] = 9'h1FF;
      end
    end
  endfunction
  // Waits, bounded, for a rise on the selected clock pins.
  task automatic wait_edge(input int s);
    logic [1:0] a;
    logic [1:0] b;
    int n;
    a = pick(s);
    n = 0;
    do begin
      @(posedge clk);
      b = a;
      a = pick(s);
      n++;
    end while (!(|(a & ~b)) && n < 40);
    if (n >= 40) begin
      num_errors++;
      end_sim();
    end
  endtask
  // Command set up during clock low, held past the positive rise.
  task automatic cmd(input logic r, input dbs_adr_t a);
    wait_edge(1);
    ld_n <= 1'b0;
    rw <= r;
    adr <= a;
    wait_edge(0);
    repeat (3) @(posedge clk);
    ld_n <= 1'b1;
    adr <= ~a;
  endtask
  // Word i is set mid-phase before its rise; bus then shows inverse.
  task automatic wr(input dbs_adr_t a, input dbs_dq_t [3:0] d,
                    input logic [3:0][3:0] b);
    cmd(1'b0, a);
    for (int i = 0; i < 5; i++) begin
      wait_edge(1 - i % 2);
      repeat (3) @(posedge clk);
      drv <= (i < 4) ? d[i] : ~d[3];
      bw_n <= (i < 4) ? b[i] : 4'hF;
    end
  endtask
  task automatic rd(input dbs_adr_t a, input dbs_dq_t [3:0] d,
                    input int lat);
    logic [1:0] eo;
    dbs_dq_t m;
    int w;
    eo = wide ? 2'b11 : 2'b01;
    m = wide ? '1 : 36'h0_0003_FFFF;
    cmd(1'b1, a);
    for (int k = 1; k <= lat + 4; k++) begin
      wait_edge(2);
      repeat (5) @(posedge clk);
      w = k - lat;
      if (w >= 0 && w < 4) begin
        check({oe, q}, {eo, d[w] & m});
      end else begin
        check({36'h0, oe}, 38'h0);
      end
    end
  endtask
  // ==========================================================
  // Scenarios.
  task automatic do_reset(input logic w);
    rst_n <= 1'b0;
    wide <= w;
    repeat (5) @(posedge clk);
    check({oe, q}, 38'h0);
    check({35'h0, ep, en, lk}, 38'h0);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_echo;
    logic [37:0] x;
    for (int t = 0; t < 2; t++) begin
      tie <= t[0];
      repeat (40) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
        wait_edge(i % 2);
        repeat (5) @(posedge clk);
        x = {35'h0, ~i[0], i[0], 1'b0};
        check({35'h0, ep, en, oe[0]}, x);
      end
    end
    tie <= 1'b0;
    repeat (40) @(posedge clk);
    $display("echo test done");
  endtask
  task automatic t_bytes;
    logic [3:0][3:0] b;
    wr(A0, D0, '0);
    rd(A0, D0, 2);
    for (int i = 0; i < 4; i++) begin
      b[i] = ~(4'h1 << i);
      exp_mem[i] = (D1[i] & lanes(b[i])) | (D0[i] & ~lanes(b[i]));
    end
    wr(A0, D1, b);
    rd(A0, exp_mem, 2);
    $display("write and byte test done");
  endtask
  task automatic t_ignore;
    for (int i = 0; i < 4; i++) begin
      wait_edge(1);
      ld_n <= 1'b0;
      rw <= 1'b0;
      adr <= A0;
      drv <= D1[i];
      bw_n <= 4'h0;
      repeat (3) @(posedge clk);
      ld_n <= 1'b1;
    end
    rd(A0, exp_mem, 2);
    // Output clocks held high: reads follow the input clock pair.
    tie <= 1'b1;
    repeat (40) @(posedge clk);
    rd(A0, exp_mem, 2);
    tie <= 1'b0;
    repeat (40) @(posedge clk);
    $display("ignore test done");
  endtask
  task automatic t_dll;
    int n;
    dll_off_n <= 1'b1;
    n = 0;
    while (lk !== 1'b1 && n < 1100) begin
      wait_edge(0);
      n++;
    end
    tests_run++;
    if (n < 1020 || n > 1030) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, n, 1024);
    end
    if (lk !== 1'b1) begin
      end_sim();
    end
    rd(A0, exp_mem, 3);
    dll_off_n <= 1'b0;
    repeat (10) @(posedge clk);
    check({37'h0, lk}, 38'h0);
    dll_off_n <= 1'b1;
    repeat (100) wait_edge(0);
    check({37'h0, lk}, 38'h0);
    dll_off_n <= 1'b0;
    rd(A0, exp_mem, 2);
    $display("dll test done");
  endtask
  task automatic t_narrow;
    wr(A1, D0, '0);
    rd(A1, D0, 2);
    $display("narrow test done");
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    do_reset(1'b1);
    t_echo();
    t_bytes();
    t_ignore();
    t_dll();
    do_reset(1'b0);
    t_narrow();
    end_sim();
  end
endmodule
